// [core/meter_port_pkg.sv]
// Package with constants and types for the meter serial port and pulse output
package meter_port_pkg;

  // Avalon-MM register map, byte addresses
  localparam int          ADDR_W             = 5;
  localparam logic [4:0]  OFS_WAVE_MODE      = 5'h00;
  localparam logic [4:0]  OFS_PULSE_NUM      = 5'h04;
  localparam logic [4:0]  OFS_PULSE_DEN      = 5'h08;
  localparam logic [4:0]  OFS_IRQ_MASK       = 5'h0c;
  localparam logic [4:0]  OFS_IRQ_STATUS     = 5'h10;

  // Field positions
  localparam int          BIT_SRC_SEL        = 0;
  localparam int          BIT_ENERGY_HALF    = 0;
  localparam int          BIT_SAMPLE_READY   = 1;
  localparam int          BIT_FIFO_EMPTY     = 2;
  localparam int          BIT_FIFO_FULL      = 3;
  localparam int          POS_LAST_CMD       = 8;

  // Widths
  localparam int          SCALE_W            = 12;
  localparam int          POWER_W            = 16;
  localparam int          ENERGY_W           = 24;
  localparam int          SAMPLE_W           = 24;
  localparam int          FIFO_DEPTH         = 16;
  localparam int          ACC_W              = 48;
  localparam int          PULSE_SHIFT        = 16;

  // Reset values
  localparam logic [11:0] RST_PULSE_NUM      = 12'h000;
  localparam logic [11:0] RST_PULSE_DEN      = 12'h000;
  localparam logic [1:0]  RST_IRQ_MASK       = 2'h0;

  // Serial command that reads one waveform sample
  localparam logic [7:0]  CMD_READ_WAVE      = 8'h01;
  localparam int          BYTE_BITS          = 8;

  // Timing
  localparam int          CLK_HZ             = 20_000_000;
  localparam int          PULSE_WIDTH_US     = 100;
  localparam int          PULSE_WIDTH_CYC    = (PULSE_WIDTH_US * (CLK_HZ / 1_000_000) > 0) ?
                                               PULSE_WIDTH_US * (CLK_HZ / 1_000_000) : 1;

  typedef struct packed {
    logic [SCALE_W-1:0] numerator;
    logic [SCALE_W-1:0] denominator;
    logic               source_sel;
  } pulse_cfg_t;

  typedef struct packed {
    logic sample_ready;
    logic energy_half;
  } irq_bits_t;

  typedef enum logic {SPI_CMD, SPI_SEND} spi_state_t;

endpackage

// [core/meter_serial_port.sv]
// Sample FIFO and meter serial port, interrupt and reactive pulse logic
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0]   count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule // sample_fifo

module meter_serial_port
  import meter_port_pkg::*;
(
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // Avalon-MM slave
  input  wire logic [meter_port_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [31:0]                         avs_writedata,
  output logic      [31:0]                         avs_readdata,
  output logic                                     avs_waitrequest,
  // Serial pins
  input  wire logic                                sclk,
  input  wire logic                                cs_n,
  input  wire logic                                din,
  output logic                                     dout_out,
  output logic                                     dout_oe,
  // Open-drain interrupt
  output logic                                     irq_n_out,
  output logic                                     irq_n_oe,
  // Measurement side
  input  wire logic                                wave_in_valid,
  output logic                                     wave_in_ready,
  input  wire logic [meter_port_pkg::SAMPLE_W-1:0] wave_in_data,
  input  wire logic [meter_port_pkg::ENERGY_W-1:0] active_energy,
  input  wire logic [meter_port_pkg::POWER_W-1:0]  reactive_power,
  input  wire logic [meter_port_pkg::POWER_W-1:0]  apparent_power,
  output logic                                     reactive_pulse_out
);
  import meter_port_pkg::*;

  // Register file
  pulse_cfg_t                cfg_ff;
  irq_bits_t                 mask_ff;
  irq_bits_t                 status_ff;
  logic                      ack_ff;
  logic [31:0]               rdata_ff;
  logic                      wr_en;
  logic                      rd_en;
  logic [31:0]               nxt_rdata;

  // Serial side
  logic [2:0]                sync1_ff;
  logic [2:0]                sync2_ff;
  logic                      sclk_prev_ff;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      selected;
  spi_state_t                spi_state_ff;
  logic [4:0]                bit_cnt_ff;
  logic [7:0]                cmd_sh_ff;
  logic [7:0]                last_cmd_ff;
  logic [SAMPLE_W-1:0]       tx_sh_ff;
  logic                      dout_ff;
  logic                      byte_done;
  logic [7:0]                cmd_byte;

  // FIFO
  logic                      fifo_out_valid;
  logic                      fifo_pop;
  logic [SAMPLE_W-1:0]       fifo_out_data;
  logic                      sample_push;

  // Energy and pulse
  logic                      half_prev_ff;
  logic                      half_rise;
  logic [ACC_W-1:0]          acc_ff;
  logic [ACC_W-1:0]          acc_sum;
  logic [ACC_W-1:0]          threshold;
  logic [POWER_W-1:0]        sel_power;
  logic [11:0]               pulse_cnt_ff;

  // Avalon slave: one wait state, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_en           = avs_write & ack_ff;
  assign rd_en           = avs_read & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address)
      OFS_WAVE_MODE: nxt_rdata[BIT_SRC_SEL] = cfg_ff.source_sel;
      OFS_PULSE_NUM: nxt_rdata[SCALE_W-1:0] = cfg_ff.numerator;
      OFS_PULSE_DEN: nxt_rdata[SCALE_W-1:0] = cfg_ff.denominator;
      OFS_IRQ_MASK: begin
        nxt_rdata[BIT_ENERGY_HALF]  = mask_ff.energy_half;
        nxt_rdata[BIT_SAMPLE_READY] = mask_ff.sample_ready;
      end
      OFS_IRQ_STATUS: begin
        nxt_rdata[BIT_ENERGY_HALF]              = status_ff.energy_half;
        nxt_rdata[BIT_SAMPLE_READY]             = status_ff.sample_ready;
        nxt_rdata[BIT_FIFO_EMPTY]               = ~fifo_out_valid;
        nxt_rdata[BIT_FIFO_FULL]                = ~wave_in_ready;
        nxt_rdata[POS_LAST_CMD+7:POS_LAST_CMD]  = last_cmd_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff.source_sel  <= 1'b0;
      cfg_ff.numerator   <= RST_PULSE_NUM;
      cfg_ff.denominator <= RST_PULSE_DEN;
      mask_ff            <= RST_IRQ_MASK;
    end else if (wr_en) begin
      case (avs_address)
        OFS_WAVE_MODE: cfg_ff.source_sel  <= avs_writedata[BIT_SRC_SEL];
        OFS_PULSE_NUM: cfg_ff.numerator   <= avs_writedata[SCALE_W-1:0];
        OFS_PULSE_DEN: cfg_ff.denominator <= avs_writedata[SCALE_W-1:0];
        OFS_IRQ_MASK: begin
          mask_ff.energy_half  <= avs_writedata[BIT_ENERGY_HALF];
          mask_ff.sample_ready <= avs_writedata[BIT_SAMPLE_READY];
        end
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  assign sample_push = wave_in_valid & wave_in_ready;
  assign half_rise   = active_energy[ENERGY_W-1] & ~half_prev_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      half_prev_ff <= 1'b0;
    end else begin
      half_prev_ff <= active_energy[ENERGY_W-1];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
    end else begin
      if (half_rise) begin
        status_ff.energy_half <= 1'b1;
      end else if (wr_en && avs_address == OFS_IRQ_STATUS && avs_writedata[BIT_ENERGY_HALF]) begin
        status_ff.energy_half <= 1'b0;
      end
      if (sample_push) begin
        status_ff.sample_ready <= 1'b1;
      end else if (wr_en && avs_address == OFS_IRQ_STATUS && avs_writedata[BIT_SAMPLE_READY]) begin
        status_ff.sample_ready <= 1'b0;
      end
    end
  end

  // Open drain: only ever drives low
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = |(status_ff & mask_ff);

  // Samples wait here; a full buffer stalls the measurement side
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (wave_in_valid),
    .in_ready  (wave_in_ready),
    .in_data   (wave_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Two-flop synchronisers for sclk, cs_n and din
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync2_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          sync1_ff[gi] <= (gi == 0) ? sclk : (gi == 1) ? cs_n : din;
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sync2_ff[0];
    end
  end

  // Serial clock comes only from the host; edges found by oversampling
  assign selected  = ~sync2_ff[1];
  assign sclk_rise = selected & sync2_ff[0] & ~sclk_prev_ff;
  assign sclk_fall = selected & ~sync2_ff[0] & sclk_prev_ff;
  assign cmd_byte  = {cmd_sh_ff[6:0], sync2_ff[2]};
  assign byte_done = sclk_fall && spi_state_ff == SPI_CMD && bit_cnt_ff == 5'(BYTE_BITS - 1);
  assign fifo_pop  = byte_done && cmd_byte == CMD_READ_WAVE && fifo_out_valid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spi_state_ff <= SPI_CMD;
      bit_cnt_ff   <= '0;
      cmd_sh_ff    <= 8'h00;
      last_cmd_ff  <= 8'h00;
    end else if (!selected) begin
      spi_state_ff <= SPI_CMD;
      bit_cnt_ff   <= '0;
    end else if (sclk_fall) begin
      case (spi_state_ff)
        SPI_CMD: begin
          cmd_sh_ff <= cmd_byte;
          if (byte_done) begin
            bit_cnt_ff  <= '0;
            last_cmd_ff <= cmd_byte;
            if (cmd_byte == CMD_READ_WAVE) begin
              spi_state_ff <= SPI_SEND;
            end
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
        end
        SPI_SEND: begin
          if (bit_cnt_ff == 5'(SAMPLE_W - 1)) begin
            bit_cnt_ff   <= '0;
            spi_state_ff <= SPI_CMD;
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
        end
        default: spi_state_ff <= SPI_CMD;
      endcase
    end
  end

  // An empty buffer sends zeros rather than stalling the host
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sh_ff <= '0;
      dout_ff  <= 1'b0;
    end else if (byte_done && cmd_byte == CMD_READ_WAVE) begin
      tx_sh_ff <= fifo_out_valid ? fifo_out_data : '0;
    end else if (sclk_rise && spi_state_ff == SPI_SEND) begin
      dout_ff  <= tx_sh_ff[SAMPLE_W-1];
      tx_sh_ff <= {tx_sh_ff[SAMPLE_W-2:0], 1'b0};
    end
  end

  assign dout_out = dout_ff;
  assign dout_oe  = selected && spi_state_ff == SPI_SEND;

  // Pulse output: power times numerator against denominator threshold
  assign sel_power = cfg_ff.source_sel ? apparent_power : reactive_power;
  assign acc_sum   = acc_ff + ACC_W'(sel_power) * ACC_W'(cfg_ff.numerator);
  assign threshold = ACC_W'({(cfg_ff.denominator == '0) ? 12'h001 : cfg_ff.denominator,
                             {PULSE_SHIFT{1'b0}}});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_ff       <= '0;
      pulse_cnt_ff <= '0;
    end else begin
      if (acc_sum >= threshold) begin
        acc_ff <= acc_sum - threshold;
      end else begin
        acc_ff <= acc_sum;
      end
      // Pulses closer than one width merge; a limit on full-scale rate
      if (acc_sum >= threshold) begin
        pulse_cnt_ff <= 12'(PULSE_WIDTH_CYC);
      end else if (pulse_cnt_ff != '0) begin
        pulse_cnt_ff <= pulse_cnt_ff - 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reactive_pulse_out <= 1'b0;
    end else begin
      reactive_pulse_out <= (pulse_cnt_ff != '0) || (acc_sum >= threshold);
    end
  end

endmodule // meter_serial_port

// [test/meter_serial_port_checker.sv]
// Pin level checker for the meter serial port
`timescale 1ns/1ps
module meter_serial_port_checker
  import meter_port_pkg::*;
(
  input logic                core_clk,
  input logic                rst,
  input logic [ADDR_W-1:0]   avs_address,
  input logic                avs_read,
  input logic                avs_write,
  input logic [31:0]         avs_writedata,
  input logic                avs_waitrequest,
  input logic                sclk,
  input logic                cs_n,
  input logic                dout_out,
  input logic                dout_oe,
  input logic                irq_n_out,
  input logic                irq_n_oe,
  input logic                wave_in_valid,
  input logic                wave_in_ready,
  input logic [ENERGY_W-1:0] active_energy,
  input logic [POWER_W-1:0]  reactive_power,
  input logic [POWER_W-1:0]  apparent_power,
  input logic                reactive_pulse_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0]  mask_ff;
  logic        src_ff;
  logic [11:0] idle_ff;
  logic        wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest;
  // Shadows of the register bits the interrupt and source checks depend on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) mask_ff <= RST_IRQ_MASK;
    else if (wr_ok && avs_address == OFS_IRQ_MASK) mask_ff <= avs_writedata[1:0];
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) src_ff <= 1'b0;
    else if (wr_ok && avs_address == OFS_WAVE_MODE) src_ff <= avs_writedata[BIT_SRC_SEL];
  end
  // Margin above the pulse width so a pulse begun before the source went quiet may finish
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) idle_ff <= 12'h0;
    else if ((src_ff ? apparent_power : reactive_power) != 16'h0) idle_ff <= 12'h0;
    else if (idle_ff != 12'hfff) idle_ff <= idle_ff + 12'h1;
  end
  sequence req_start_s;
    $rose(avs_read || avs_write);
  endsequence
  sequence one_wait_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  bus_wait_a: assert property (req_start_s |-> one_wait_s)
    else $error("bus answer not after one wait state");
  irq_low_a: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin would drive high");
  sel_only_a: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data out driven while not selected");
  oe_cause_a: assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n, 60))
    else $error("data out driven without a command byte");
  launch_rise_a: assert property ($fell(sclk) && dout_oe |=> (!dout_oe || $stable(dout_out)) [*4])
    else $error("data out changed after a falling clock");
  sample_irq_a: assert property (wave_in_valid && wave_in_ready && mask_ff[1] |=> irq_n_oe)
    else $error("no interrupt for a new sample");
  irq_masked_a: assert property (irq_n_oe |-> mask_ff != 2'h0)
    else $error("interrupt with all sources masked");
  energy_irq_a: assert property ($rose(active_energy[23]) && mask_ff[0] |-> ##[1:3] irq_n_oe)
    else $error("no interrupt at half energy");
  idle_source_a: assert property (idle_ff > 12'd2100 |-> !reactive_pulse_out)
    else $error("pulse from an idle power source");
endmodule // meter_serial_port_checker

bind meter_serial_port meter_serial_port_checker meter_serial_port_checker_i (
  .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .sclk, .cs_n, .dout_out, .dout_oe, .irq_n_out, .irq_n_oe, .wave_in_valid, .wave_in_ready,
  .active_energy, .reactive_power, .apparent_power, .reactive_pulse_out
);

// [test/meter_serial_port_tb.sv]
// Self-checking bench for the meter serial port
`timescale 1ns/1ps
module meter_serial_port_tb;
  import meter_port_pkg::*;
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic [ADDR_W-1:0]   avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = '0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest, sclk, cs_n, din, dout_out, dout_oe, irq_n_out, irq_n_oe;
  logic                wave_in_valid = 1'b0;
  logic                wave_in_ready;
  logic [SAMPLE_W-1:0] wave_in_data = '0;
  logic [ENERGY_W-1:0] active_energy = '0;
  logic [POWER_W-1:0]  reactive_power = '0;
  logic [POWER_W-1:0]  apparent_power = '0;
  logic                reactive_pulse_out;
  logic [31:0]         r;
  logic [23:0]         d;
  int                  failures = 0;
  int                  cmp_count = 0;
  int                  n;
  always #25 core_clk = !core_clk;
  meter_serial_port meter_serial_port_i (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .sclk, .cs_n, .din, .dout_out, .dout_oe,
    .irq_n_out, .irq_n_oe, .wave_in_valid, .wave_in_ready, .wave_in_data, .active_energy,
    .reactive_power, .apparent_power, .reactive_pulse_out);
  spi_host_model spi_host_model_i (.core_clk, .dout_out, .dout_oe, .sclk, .cs_n, .din);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 40) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    tmo(k);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  task automatic push(input logic [23:0] v);
    int k;
    k = 0;
    @(posedge core_clk);
    wave_in_valid <= 1'b1;
    wave_in_data <= v;
    do begin
      @(posedge core_clk);
      k++;
    end while (wave_in_ready !== 1'b1 && k < 40);
    wave_in_valid <= 1'b0;
    tmo(k);
  endtask
  task automatic lvl(input logic v, input int lim);
    while (reactive_pulse_out !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic t_regs;
    rdc(OFS_PULSE_NUM, 32'hfff, {20'h0, RST_PULSE_NUM});
    rdc(OFS_PULSE_DEN, 32'hfff, {20'h0, RST_PULSE_DEN});
    rdc(OFS_IRQ_MASK, 32'h3, {30'h0, RST_IRQ_MASK});
    rdc(OFS_IRQ_STATUS, 32'hf, 32'h4);
    bus(1'b1, OFS_PULSE_NUM, 32'h5a5);
    rdc(OFS_PULSE_NUM, 32'hfff, 32'h5a5);
    bus(1'b1, 5'h14, 32'hffff);
    rdc(5'h14, 32'hffffffff, 32'h0);
    chk({30'h0, irq_n_oe, irq_n_out}, 32'h0);
  endtask
  task automatic t_sample;
    bus(1'b1, OFS_IRQ_MASK, 32'h2);
    push(24'ha5c37e);
    @(posedge core_clk);
    chk({31'h0, irq_n_oe}, 32'h1);
    spi_host_model_i.xfer(CMD_READ_WAVE, 32, 1'b1, d);
    chk({8'h0, d}, 32'ha5c37e);
    rdc(OFS_IRQ_STATUS, 32'hff02, {16'h0, CMD_READ_WAVE, 8'h02});
    bus(1'b1, OFS_IRQ_STATUS, 32'h2);
    @(posedge core_clk);
    chk({30'h0, irq_n_oe, dout_oe}, 32'h0);
  endtask
  task automatic t_select;
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    push(24'h5a0f3c);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq_n_oe}, 32'h0);
    spi_host_model_i.xfer(CMD_READ_WAVE, 32, 1'b0, d);
    chk({8'h0, d}, {8'h0, 24'hzzzzzz});
    spi_host_model_i.xfer(CMD_READ_WAVE, 4, 1'b1, d);
    spi_host_model_i.xfer(CMD_READ_WAVE, 32, 1'b1, d);
    chk({8'h0, d}, 32'h5a0f3c);
    spi_host_model_i.xfer(8'h3c, 32, 1'b1, d);
    chk({8'h0, d}, {8'h0, 24'hzzzzzz});
    // Toggling filler after an unknown command forms further bytes 0xaa
    rdc(OFS_IRQ_STATUS, 32'hff00, 32'haa00);
  endtask
  task automatic t_fifo;
    for (int i = 0; i < FIFO_DEPTH; i++) push({8'(i), 16'hc0de});
    @(posedge core_clk);
    chk({31'h0, wave_in_ready}, 32'h0);
    rdc(OFS_IRQ_STATUS, 32'hc, 32'h8);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      spi_host_model_i.xfer(CMD_READ_WAVE, 32, 1'b1, d);
      chk({8'h0, d}, i < FIFO_DEPTH ? {8'h0, 8'(i), 16'hc0de} : 32'h0);
    end
    rdc(OFS_IRQ_STATUS, 32'hc, 32'h4);
  endtask
  task automatic t_energy;
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    active_energy <= 24'h7fffff;
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq_n_oe}, 32'h0);
    active_energy <= 24'h800000;
    repeat (4) @(posedge core_clk);
    chk({31'h0, irq_n_oe}, 32'h1);
    bus(1'b1, OFS_IRQ_STATUS, 32'h1);
    @(posedge core_clk);
    chk({31'h0, irq_n_oe}, 32'h0);
  endtask
  task automatic t_pulse;
    bus(1'b1, OFS_PULSE_DEN, 32'hfff);
    bus(1'b1, OFS_PULSE_NUM, 32'h1);
    apparent_power <= 16'hffff;
    n = 0;
    lvl(1'b1, 5000);
    chk(n, 5000);
    bus(1'b1, OFS_WAVE_MODE, 32'h1);
    n = 0;
    lvl(1'b1, 4300);
    chk(n >= 4090 && n <= 4100, 1);
    bus(1'b1, OFS_PULSE_NUM, 32'h2);
    n = 0;
    lvl(1'b0, 2100);
    lvl(1'b1, 4300);
    chk(n < 4300, 1);
    n = 0;
    lvl(1'b0, 2100);
    lvl(1'b1, 4300);
    chk(n >= 2040 && n <= 2056, 1);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_sample();
    t_select();
    t_fifo();
    t_energy();
    t_pulse();
    report_and_stop();
  end
endmodule // meter_serial_port_tb

// [test/spi_host_model.sv]
// Host model that masters the four-wire serial bus
`timescale 1ns/1ps
module spi_host_model (
  input  logic core_clk,
  input  logic dout_out,
  input  logic dout_oe,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  int   half = 4;
  logic dout_w;
  // No pull on the data line, so a released line reads as high impedance
  assign dout_w = dout_oe ? dout_out : 1'bz;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input int n, input logic sel, output logic [23:0] rd);
    rd = 24'h0;
    repeat (half) @(posedge core_clk);
    cs_n <= !sel;
    for (int i = 0; i < n; i++) begin
      din <= (i < 8) ? cmd[7-i] : !din;
      repeat (half) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (half / 2) @(posedge core_clk);
      if (i >= 8) rd = {rd[22:0], dout_w};
      repeat (half - half / 2) @(posedge core_clk);
      sclk <= 1'b1;
    end
    repeat (half) @(posedge core_clk);
    cs_n <= 1'b1;
    din <= !din;
  endtask
endmodule // spi_host_model
